//--- hw/serial_flash_cmd_status.sv
// Serial flash instruction front end with status register and write latch.
`timescale 1ns/100ps
module serial_flash_cmd_status
    import flash_cmd_pkg::*;
(
    input wire logic ref_clk_in,         // Core clock, 250 MHz.
    input wire logic resetn_in,          // Asynchronous reset, active low.
    input wire logic sclk_in,            // Serial clock from the host.
    input wire logic select_n_in,        // Chip select, active low.
    input wire logic serial_in_io_in,    // Serial command data in.
    input wire logic write_guard_n_in,   // Write guard pin, active low.
    input wire logic [5:0] query_block_in, // Block number to check.
    output logic serial_out_out,         // Serial data out.
    output logic serial_out_oe_out,      // Output enable of serial out.
    output logic block_locked_out        // Queried block is read-only.
);
    // Link domain is held in reset while the frame is closed.
    wire link_rst_n = resetn_in & ~select_n_in;

    logic [2:0] bit_q;
    logic [2:0] byte_q;
    logic [6:0] shift_q;
    logic [7:0] cmd_q;
    logic [7:0] tx_q;
    logic frame_tog_q;
    frame_res_e res_q;
    frame_res_e res_d;
    logic [7:0] res_data_q;
    logic [7:0] stat_l1_q;
    logic [7:0] stat_l2_q;
    logic dout_q;
    logic oe_q;
    // Core-domain registers and the status word that the link samples.
    logic sel_s1_q;
    logic sel_s2_q;
    logic sel_prev_q;
    logic guard_s1_q;
    logic guard_s2_q;
    logic tog_s1_q;
    logic tog_s2_q;
    logic tog_seen_q;
    logic latch_q;
    logic lock_q;
    logic bottom_q;
    logic [2:0] range_q;
    logic [11:0] timer_q;
    wr_state_e state_q;
    logic locked_q;
    logic [11:0] busy_cnt_q;
    wire busy = (state_q != WR_IDLE);
    // Status byte with busy and latch read-only, bit 6 zero.
    wire [7:0] status_word = {lock_q, 1'b0, bottom_q, range_q,
                              latch_q, busy};

    // Byte being completed on this edge and the opcode in force.
    wire [7:0] rx_byte = {shift_q, serial_in_io_in};
    wire byte_end = (bit_q == 3'h7);
    wire [7:0] cmd_now = (byte_q == 3'h0) ? rx_byte : cmd_q;
    wire busy_l = stat_l2_q[ST_BUSY];

    // Framing counters and input shifter, rising edge.
    always_ff @(posedge sclk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_q <= 3'h0;
            byte_q <= 3'h0;
            shift_q <= 7'h00;
            cmd_q <= 8'h00;
        end else begin
            bit_q <= bit_q + 3'h1;
            shift_q <= rx_byte[6:0];
            if (byte_end && byte_q != 3'h7) begin
                byte_q <= byte_q + 3'h1;
            end
            if (byte_end && byte_q == 3'h0) begin
                cmd_q <= rx_byte;
            end
        end
    end

    // Outcome of the frame so far; any extra bit voids a write.
    always_comb begin
        res_d = RES_NONE;
        if (byte_end && byte_q == 3'h0 && rx_byte == OPC_WRITE_ENABLE) begin
            res_d = RES_SET_LATCH;
        end else if (byte_end && byte_q == 3'h0 &&
                     rx_byte == OPC_WRITE_DISABLE) begin
            res_d = RES_CLR_LATCH;
        end else if (byte_end && byte_q == 3'h1 &&
                     cmd_q == OPC_WRITE_STATUS) begin
            res_d = RES_STATUS;
        end
    end

    // Results survive the frame end; the toggle marks a clocked frame.
    always_ff @(posedge sclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            res_q <= RES_NONE;
            res_data_q <= 8'h00;
            frame_tog_q <= 1'b0;
            stat_l1_q <= 8'h00;
            stat_l2_q <= 8'h00;
            tx_q <= 8'h00;
        end else begin
            res_q <= select_n_in ? res_q : res_d;
            if (!select_n_in && byte_end && byte_q == 3'h1) begin
                res_data_q <= rx_byte;
            end
            if (!select_n_in && bit_q == 3'h0 && byte_q == 3'h0) begin
                frame_tog_q <= ~frame_tog_q;
            end
            stat_l1_q <= status_word;
            stat_l2_q <= stat_l1_q;
            // Reload at each byte boundary so the latest status repeats.
            if (byte_end) begin
                tx_q <= (cmd_now == OPC_READ_STATUS) ? stat_l2_q
                                                     : DEVICE_ID;
            end
        end
    end

    // Answer phase: status any time, identifier only when not busy.
    wire send_status = (cmd_q == OPC_READ_STATUS) && (byte_q != 3'h0);
    wire send_id = (cmd_q == OPC_READ_ID) && (byte_q >= ID_FIRST_BYTE) &&
                   !busy_l;

    // Output bits change on falling edges, MSB first.
    always_ff @(negedge sclk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            dout_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            oe_q <= send_status || send_id;
            dout_q <= tx_q[3'h7 - bit_q];
        end
    end

    assign serial_out_out = dout_q;
    assign serial_out_oe_out = oe_q;

    // Frame-end detection and the decision to run a status write.
    wire frame_go = sel_s2_q && !sel_prev_q && (tog_s2_q != tog_seen_q);
    wire exec_go = frame_go && !busy;
    wire guard_ok = !lock_q || guard_s2_q;
    wire wr_accept = exec_go && res_q == RES_STATUS && latch_q &&
                     guard_ok;

    // Decides whether a block falls in the protected span.
    function automatic logic block_locked(input logic from_bottom,
                                          input logic [2:0] range,
                                          input logic [5:0] blk);
        logic [6:0] span;
        span = (range == 3'h0) ? 7'h00 :
               (range == 3'h7) ? BLOCK_COUNT :
               7'(7'h01 << (range - 3'h1));
        if (from_bottom) begin
            block_locked = {1'b0, blk} < span;
        end else begin
            block_locked = {1'b0, blk} >= 7'(BLOCK_COUNT - span);
        end
    endfunction

    // Synchronisers and the frame-end detector.
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sel_s1_q <= 1'b1;
            sel_s2_q <= 1'b1;
            sel_prev_q <= 1'b1;
            guard_s1_q <= 1'b1;
            guard_s2_q <= 1'b1;
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_seen_q <= 1'b0;
        end else begin
            sel_s1_q <= select_n_in;
            sel_s2_q <= sel_s1_q;
            sel_prev_q <= sel_s2_q;
            guard_s1_q <= write_guard_n_in;
            guard_s2_q <= guard_s1_q;
            tog_s1_q <= frame_tog_q;
            tog_s2_q <= tog_s1_q;
            if (sel_s2_q && !sel_prev_q) begin
                tog_seen_q <= tog_s2_q;
            end
        end
    end

    // Write latch, non-volatile bits and the self-timed write sequencer.
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            latch_q <= RST_LATCH;
            lock_q <= RST_LOCK;
            bottom_q <= RST_BOTTOM;
            range_q <= RST_RANGE;
            timer_q <= 12'h000;
            state_q <= WR_IDLE;
            locked_q <= 1'b0;
            busy_cnt_q <= 12'h000;
        end else begin
            locked_q <= block_locked(bottom_q, range_q,
                                     query_block_in);
            busy_cnt_q <= busy ? busy_cnt_q + 12'h001 : 12'h000; // Span.
            unique case (state_q)
                WR_IDLE: begin
                    if (exec_go && res_q == RES_SET_LATCH) begin
                        latch_q <= 1'b1;
                    end
                    if (exec_go && res_q == RES_CLR_LATCH) begin
                        latch_q <= 1'b0;
                    end
                    if (wr_accept) begin
                        lock_q <= res_data_q[ST_LOCK];
                        bottom_q <= res_data_q[ST_BOTTOM];
                        range_q <= res_data_q[ST_RANGE_LO +: 3];
                        timer_q <= WRITE_CYCLES;
                        state_q <= WR_RUN;
                    end
                end
                WR_RUN: begin
                    timer_q <= timer_q - 12'h001;
                    if (timer_q == 12'h001) begin
                        latch_q <= 1'b0;
                        state_q <= WR_DONE;
                    end
                end
                WR_DONE: begin
                    state_q <= WR_IDLE;
                end
            endcase
        end
    end

    assign block_locked_out = locked_q;

    property p_set_latch;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        exec_go && res_q == RES_SET_LATCH |=> latch_q;
    endproperty
    a_set_latch: assert property (p_set_latch)
        else $error("Write enable did not set the latch.");

    property p_clr_latch;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        exec_go && res_q == RES_CLR_LATCH |=> !latch_q;
    endproperty
    a_clr_latch: assert property (p_clr_latch)
        else $error("Write disable did not clear the latch.");

    property p_refuse_unlatched;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        exec_go && res_q == RES_STATUS && !latch_q |=>
            state_q == WR_IDLE && $stable(range_q) && $stable(lock_q);
    endproperty
    a_refuse_unlatched: assert property (p_refuse_unlatched)
        else $error("Status write ran without the latch set.");

    property p_guard_lock;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        exec_go && res_q == RES_STATUS && lock_q && !guard_s2_q |=>
            state_q == WR_IDLE;
    endproperty
    a_guard_lock: assert property (p_guard_lock)
        else $error("Status write ran while locked by the guard pin.");

    property p_guard_free;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        exec_go && res_q == RES_STATUS && latch_q && !lock_q |=>
            state_q == WR_RUN;
    endproperty
    a_guard_free: assert property (p_guard_free)
        else $error("Unlocked status write was refused.");

    property p_write_fields;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        wr_accept |=> lock_q == $past(res_data_q[ST_LOCK]) &&
            bottom_q == $past(res_data_q[ST_BOTTOM]) &&
            range_q == $past(res_data_q[4:2]) && latch_q;
    endproperty
    a_write_fields: assert property (p_write_fields)
        else $error("Status write stored the wrong bits.");

    property p_busy_span;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        $fell(status_word[ST_BUSY]) |->
            busy_cnt_q == WRITE_CYCLES + 12'h001;
    endproperty
    a_busy_span: assert property (p_busy_span)
        else $error("Busy flag did not span the self-timed write.");

    property p_latch_end;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        state_q == WR_RUN && timer_q == 12'h001 |=>
            !latch_q ##1 !busy && !latch_q;
    endproperty
    a_latch_end: assert property (p_latch_end)
        else $error("Latch not cleared at status write completion.");

    property p_busy_ignore;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        frame_go && state_q == WR_RUN && timer_q > 12'h001 |=>
            $stable(latch_q) && $stable(lock_q);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore)
        else $error("Instruction acted while busy.");

    property p_unknown_op;
        @(posedge sclk_in) disable iff (!link_rst_n)
        byte_end && byte_q == 3'h0 && rx_byte != OPC_WRITE_ENABLE &&
            rx_byte != OPC_WRITE_DISABLE |=> res_q == RES_NONE;
    endproperty
    a_unknown_op: assert property (p_unknown_op)
        else $error("Unknown opcode produced an action.");
endmodule

//--- hw/flash_cmd_pkg.sv
// Constants and types shared by the serial flash command and status logic.
package flash_cmd_pkg;
    // Opcodes recognised by the command front end.
    localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OPC_READ_STATUS = 8'h05;
    localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OPC_READ_ID = 8'hAB;
    // One-byte device identifier; the value is arbitrary.
    localparam logic [7:0] DEVICE_ID = 8'h5A;
    // Status field positions.
    localparam int ST_BUSY = 0;
    localparam int ST_LATCH = 1;
    localparam int ST_RANGE_LO = 2;
    localparam int ST_BOTTOM = 5;
    localparam int ST_RESERVED = 6;
    localparam int ST_LOCK = 7;
    // Values after reset (factory defaults of the non-volatile bits).
    localparam logic RST_LOCK = 1'b0;
    localparam logic RST_BOTTOM = 1'b0;
    localparam logic [2:0] RST_RANGE = 3'h0;
    localparam logic RST_LATCH = 1'b0;
    // Byte index that carries the first identifier byte.
    localparam logic [2:0] ID_FIRST_BYTE = 3'h4;
    localparam logic [6:0] BLOCK_COUNT = 7'h40;
    // Self-timed status write duration and its cycle count.
    localparam int CLK_PERIOD_NS = 4;
    localparam int STATUS_WRITE_TIME_NS = 10000;
    localparam int STATUS_WRITE_CYCLES =
        (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] WRITE_CYCLES = 12'(STATUS_WRITE_CYCLES);
    // Outcome of one framed instruction, as seen at the link.
    typedef enum logic [1:0] {
        RES_NONE, RES_SET_LATCH, RES_CLR_LATCH, RES_STATUS
    } frame_res_e;
    // Self-timed write sequencer states.
    typedef enum logic [1:0] {WR_IDLE, WR_RUN, WR_DONE} wr_state_e;
endpackage

//--- verif/spi_host_model.sv
// SPI host model that frames instructions for the serial flash.
`timescale 1ns/100ps
module spi_host_model (
    output logic sclk_out,          // Serial clock, parked low.
    output logic select_n_out,      // Chip select, active low.
    output logic serial_in_out,     // Command data to the flash.
    input wire logic serial_out_in, // Data from the flash.
    input wire logic oe_in          // Flash output enable.
);
    // Idle bus: select high and the serial clock stopped.
    initial begin
        sclk_out = 1'b0;
        select_n_out = 1'b1;
        serial_in_out = 1'b0;
    end

    // Sends n bits of tx and captures n bits of the answer on rising edges.
    task automatic frame(input int n, input logic [47:0] tx,
                         output logic [47:0] rx, output logic oe_seen);
        rx = '0;
        oe_seen = 1'b0;
        #7.3 select_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            #31.2 serial_in_out = tx[i];
            #31.3 sclk_out = 1'b1;
            rx = {rx[46:0], serial_out_in};
            oe_seen = oe_seen | oe_in;
            #62.5 sclk_out = 1'b0;
        end
        #62.5 select_n_out = 1'b1;
        // A released data line must not keep its last value.
        serial_in_out = ~serial_in_out;
        #100;
    endtask
endmodule

//--- verif/serial_flash_cmd_status_test.sv
// Self-checking bench for the serial flash command and status block.
`timescale 1ns/100ps
module serial_flash_cmd_status_test;
    import flash_cmd_pkg::*;
    typedef struct {int n; logic [47:0] tx; logic [7:0] st;} row_s;
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic sclk_in, select_n_in, serial_in_io_in;
    logic write_guard_n_in = 1'b1;
    logic [5:0] query_block_in = 6'h00;
    logic serial_out_out, serial_out_oe_out, block_locked_out;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [47:0] rx;
    logic oe;
    row_s rows [9];

    // Core clock at 250 MHz.
    always #2 ref_clk_in = ~ref_clk_in;

    serial_flash_cmd_status i_dut (
        .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .sclk_in(sclk_in),
        .select_n_in(select_n_in), .serial_in_io_in(serial_in_io_in),
        .write_guard_n_in(write_guard_n_in),
        .query_block_in(query_block_in), .serial_out_out(serial_out_out),
        .serial_out_oe_out(serial_out_oe_out),
        .block_locked_out(block_locked_out));

    spi_host_model i_host (
        .sclk_out(sclk_in), .select_n_out(select_n_in),
        .serial_in_out(serial_in_io_in), .serial_out_in(serial_out_out),
        .oe_in(serial_out_oe_out));

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Compares one byte and counts the result.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Frames one instruction and keeps the captured answer.
    task automatic send(input int n, input logic [47:0] tx);
        i_host.frame(n, tx, rx, oe);
    endtask

    // Reads the status byte once.
    task automatic rdst(output logic [7:0] st);
        i_host.frame(16, 48'h0500, rx, oe);
        st = rx[7:0];
    endtask

    // Polls status until busy clears, with a bounded number of reads.
    task automatic poll(output logic [7:0] st);
        st = 8'h01;
        for (int k = 0; k < 40 && st[0] !== 1'b0; k++) begin
            rdst(st);
        end
    endtask

    // Enables writes, writes the status byte and waits for completion.
    task automatic wstat(input logic [7:0] d, output logic [7:0] st);
        send(8, 48'h06);
        send(16, {40'h01, d});
        poll(st);
    endtask

    // Sets the queried block and checks the protection answer.
    task automatic blk(input logic [5:0] q, input logic e);
        @(posedge ref_clk_in) query_block_in <= q;
        repeat (3) @(posedge ref_clk_in);
        chk(8'(block_locked_out), 8'(e));
    endtask

    // Cuts a hung run short.
    initial begin
        #390000;
        n_mismatch++;
        final_report();
    end

    initial begin
        logic [7:0] st;
        time t0;
        rows = '{'{8, 48'h06, 8'h02}, '{8, 48'h04, 8'h00},
                 '{8, 48'h06, 8'h02}, '{9, 48'h08, 8'h02},
                 '{8, 48'hFF, 8'h02}, '{8, 48'h04, 8'h00},
                 '{16, 48'h01FC, 8'h00}, '{8, 48'h06, 8'h02},
                 '{17, 48'h03F8, 8'h02}};
        repeat (2) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        // Latch set and clear, refused writes, unknown opcode.
        foreach (rows[i]) begin
            send(rows[i].n, rows[i].tx);
            rdst(st);
            chk(st, rows[i].st);
        end
        // Status repeats while select stays low.
        i_host.frame(24, 48'h050000, rx, oe);
        chk(rx[15:8], 8'h02);
        chk(rx[7:0], 8'h02);
        // Identifier after three dummy bytes, repeated.
        i_host.frame(48, 48'hAB0000000000, rx, oe);
        chk(rx[15:8], DEVICE_ID);
        chk(rx[7:0], DEVICE_ID);
        chk(8'(oe), 8'h01);
        // Valid status write, probed while busy.
        send(16, 48'h01FF);
        t0 = $time;
        rdst(st);
        chk(st & 8'h03, 8'h03);
        send(8, 48'h04);
        i_host.frame(40, 48'hAB00000000, rx, oe);
        chk(8'(oe), 8'h00);
        poll(st);
        chk(8'($time - t0 >= 9800), 8'h01);
        chk(st, 8'hBC);
        // Lock set: guard low refuses, guard high accepts.
        @(posedge ref_clk_in) write_guard_n_in <= 1'b0;
        wstat(8'h00, st);
        chk(st, 8'hBE);
        @(posedge ref_clk_in) write_guard_n_in <= 1'b1;
        wstat(8'h00, st);
        chk(st, 8'h00);
        @(posedge ref_clk_in) write_guard_n_in <= 1'b0;
        wstat(8'h1C, st);
        chk(st, 8'h1C);
        // Protected ranges from both ends.
        blk(6'h00, 1'b1);
        wstat(8'h24, st);
        blk(6'h00, 1'b1);
        blk(6'h01, 1'b0);
        wstat(8'h04, st);
        blk(6'h3F, 1'b1);
        blk(6'h3E, 1'b0);
        // Reset after a write enable clears the latch and the status.
        send(8, 48'h06);
        @(posedge ref_clk_in) resetn_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        rdst(st);
        chk(st, 8'h00);
        final_report();
    end
endmodule
